// [rtl/csi_pkg.sv]
/*
 * Shared constants and types for the camera sensor input port.
 * Assumes a parallel sensor bus of sixteen bits with embedded timing
 * codes carried on the low component lane.
 */
package csi_pkg;

    // Bus and component widths
    localparam int BUS_W = 16;
    localparam int COMP_W = 8;

    // Word pipeline depth; holds the three preamble words plus output
    localparam int PIPE_D = 4;

    // Timing code preamble values
    localparam logic [COMP_W-1:0] PRE_ONES = 8'hff;
    localparam logic [COMP_W-1:0] PRE_ZERO = 8'h00;

    // Bit positions in the status word of a timing code
    localparam int XY_FIXED = 7;
    localparam int XY_F = 6;
    localparam int XY_V = 5;
    localparam int XY_H = 4;

    // Operating configurations of the port
    typedef enum logic [1:0] {
        MODE_BT656  = 2'h0,
        MODE_BT1120 = 2'h1,
        MODE_GATED  = 2'h2,
        MODE_ALT    = 2'h3
    } mode_t;

    // Preamble search states, Gray coded
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_ONES  = 2'h1,
        ST_ZERO1 = 2'h3,
        ST_ZERO2 = 2'h2
    } pre_st_t;

    // One captured word with its tags
    typedef struct packed {
        logic v;
        logic sof;
        logic sol;
        logic [BUS_W-1:0] data;
    } word_t;

endpackage

// [rtl/cam_word_if.sv]
/*
 * Carrier between the timing decoder and the port top.
 * Assumes the decoder end runs on the sensor pixel clock; the top takes stb and w there and the levels on the reference clock.
 */
`timescale 1ns/1ps
interface cam_word_if;
    import csi_pkg::*;
    logic stb;
    word_t w;
    logic frame_lvl;
    logic line_lvl;
    modport dec (output stb, output w, output frame_lvl, output line_lvl);
    modport top (input stb, input w, input frame_lvl, input line_lvl);
endinterface

// [rtl/cam_timing_decoder.sv]
/*
 * Timing recovery on the pixel clock: embedded code detection and
 * removal, or framing from the dedicated sync inputs.
 * Assumes inputs are already registered on the pixel clock.
 */
`timescale 1ns/1ps
module cam_timing_decoder (
    input wire logic pix_clk_i, // Sensor pixel clock
    input wire logic prst_n_i, // Pixel domain reset, active low
    input wire csi_pkg::mode_t mode_i, // Synchronised mode
    input wire logic [csi_pkg::BUS_W-1:0] bus_i, // Registered pixel bus
    input wire logic fs_i, // Registered frame sync
    input wire logic ls_i, // Registered line sync
    cam_word_if.dec wo // Decoded word stream
);
    import csi_pkg::*;

    logic emb;
    logic [COMP_W-1:0] lo;
    logic code_hit;
    logic is_sav;
    logic is_eav;
    word_t e;
    pre_st_t st_r, st_nxt;
    logic active_r, active_nxt;
    logic vblank_r, vblank_nxt;
    logic first_r, first_nxt;
    logic arm_r, arm_nxt;
    logic fs_d_r, ls_d_r;
    logic line_r, line_nxt;
    logic frame_r, frame_nxt;
    word_t pipe_r [PIPE_D];
    word_t pipe_nxt [PIPE_D];

    // Mode decode and code qualification
    assign emb = (mode_i == MODE_BT656) || (mode_i == MODE_BT1120);
    assign lo = bus_i[COMP_W-1:0];
    assign code_hit = emb && (st_r == ST_ZERO2) && lo[XY_FIXED];
    assign is_sav = code_hit && !lo[XY_H];
    assign is_eav = code_hit && lo[XY_H];

    // Preamble search: one all-ones word then two all-zeros words
    always_comb begin
        st_nxt = ST_IDLE;
        case (st_r)
            ST_IDLE: begin
                if (lo == PRE_ONES) st_nxt = ST_ONES;
            end
            ST_ONES: begin
                if (lo == PRE_ZERO) st_nxt = ST_ZERO1;
                else if (lo == PRE_ONES) st_nxt = ST_ONES;
            end
            ST_ZERO1: begin
                if (lo == PRE_ZERO) st_nxt = ST_ZERO2;
                else if (lo == PRE_ONES) st_nxt = ST_ONES;
            end
            ST_ZERO2: begin
                if (lo == PRE_ONES) st_nxt = ST_ONES;
            end
            default: st_nxt = ST_IDLE;
        endcase
        if (!emb) st_nxt = ST_IDLE;
    end

    // Entry word, line and frame tracking
    always_comb begin
        e.data = bus_i;
        if (mode_i == MODE_BT656) begin
            e.data = {{(BUS_W-COMP_W){1'h0}}, lo};
        end
        active_nxt = active_r;
        vblank_nxt = vblank_r;
        first_nxt = first_r;
        arm_nxt = arm_r;
        if (emb) begin
            e.v = active_r && !code_hit;
            e.sol = first_r;
            e.sof = first_r && arm_r;
            if (code_hit) vblank_nxt = lo[XY_V];
            if (is_sav && !lo[XY_V]) active_nxt = 1'h1;
            else if (is_eav) active_nxt = 1'h0;
            if (is_sav) first_nxt = 1'h1;
            else if (e.v) first_nxt = 1'h0;
            if (code_hit && lo[XY_V]) arm_nxt = 1'h1;
            else if (e.v && e.sof) arm_nxt = 1'h0;
            line_nxt = active_nxt;
            frame_nxt = !vblank_nxt;
        end else begin
            e.v = ls_i;
            e.sol = ls_i && !ls_d_r;
            e.sof = e.sol && arm_r;
            if (fs_i && !fs_d_r) arm_nxt = 1'h1;
            else if (e.v && e.sof) arm_nxt = 1'h0;
            line_nxt = ls_i;
            frame_nxt = fs_i;
        end
    end

    // Word pipeline; a timing code drops the preamble words behind it
    always_comb begin
        pipe_nxt[0] = e;
        for (int i = 1; i < PIPE_D; i++) begin
            pipe_nxt[i] = pipe_r[i-1];
        end
        if (code_hit) begin
            for (int i = 0; i < PIPE_D; i++) begin
                pipe_nxt[i].v = 1'h0;
            end
        end
    end

    // State registers
    always_ff @(posedge pix_clk_i or negedge prst_n_i) begin
        if (!prst_n_i) begin
            st_r <= ST_IDLE;
            active_r <= 1'h0;
            vblank_r <= 1'h1;
            first_r <= 1'h0;
            arm_r <= 1'h0;
            fs_d_r <= 1'h0;
            ls_d_r <= 1'h0;
            line_r <= 1'h0;
            frame_r <= 1'h0;
            for (int i = 0; i < PIPE_D; i++) pipe_r[i] <= '0;
        end else begin
            st_r <= st_nxt;
            active_r <= active_nxt;
            vblank_r <= vblank_nxt;
            first_r <= first_nxt;
            arm_r <= arm_nxt;
            fs_d_r <= fs_i;
            ls_d_r <= ls_i;
            line_r <= line_nxt;
            frame_r <= frame_nxt;
            for (int i = 0; i < PIPE_D; i++) pipe_r[i] <= pipe_nxt[i];
        end
    end

    assign wo.stb = pipe_r[PIPE_D-1].v;
    assign wo.w = pipe_r[PIPE_D-1];
    assign wo.line_lvl = line_r;
    assign wo.frame_lvl = frame_r;

    // Checks on code handling and capture
    a_code_removed: assert property (@(posedge pix_clk_i)
        disable iff (!prst_n_i)
        code_hit |=> !pipe_r[0].v && !pipe_r[PIPE_D-1].v)
        else $error("timing code word left in stream");
    a_sav_opens: assert property (@(posedge pix_clk_i)
        disable iff (!prst_n_i)
        is_sav && !lo[XY_V] |=> active_r && line_r)
        else $error("active line not opened by start code");
    a_eav_closes: assert property (@(posedge pix_clk_i)
        disable iff (!prst_n_i)
        is_eav |=> !active_r && !line_r)
        else $error("active line not closed by end code");
    a_blank_quiet: assert property (@(posedge pix_clk_i)
        disable iff (!prst_n_i)
        (emb && !active_r) [*3] |=> !pipe_r[2].v)
        else $error("blanking word taken as pixel");
    a_gated_accept: assert property (@(posedge pix_clk_i)
        disable iff (!prst_n_i)
        !emb && ls_i |=> pipe_r[0].v && pipe_r[0].data == $past(bus_i))
        else $error("gated word not captured");
    a_gated_sof: assert property (@(posedge pix_clk_i)
        disable iff (!prst_n_i)
        !emb && ls_i && !ls_d_r && arm_r |=> pipe_r[0].sof && pipe_r[0].v)
        else $error("first gated line not marked as frame start");
    a_bt656_one: assert property (@(posedge pix_clk_i)
        disable iff (!prst_n_i)
        mode_i == MODE_BT656 && active_r && !code_hit |=>
        pipe_r[0].v && pipe_r[0].data[COMP_W-1:0] == $past(lo) &&
        pipe_r[0].data[BUS_W-1:COMP_W] == '0)
        else $error("one component per cycle not kept");
    a_bt1120_two: assert property (@(posedge pix_clk_i)
        disable iff (!prst_n_i)
        mode_i == MODE_BT1120 && active_r && !code_hit |=>
        pipe_r[0].v && pipe_r[0].data == $past(bus_i))
        else $error("two components per cycle not kept");
    a_sync_embedded: assert property (@(posedge pix_clk_i)
        disable iff (!prst_n_i)
        emb && !code_hit && $past(emb) |=> line_r == $past(line_r))
        else $error("line level moved without a timing code");

endmodule

// [rtl/camera_sensor_input_port.sv]
/*
 * Camera sensor input port top: pin capture on the pixel clock, timing
 * recovery, and word crossing into the reference clock domain.
 * Assumes the pixel clock and reference clock are unrelated and that
 * mode_i is held steady while frames arrive.
 */
`timescale 1ns/1ps
module camera_sensor_input_port (
    input wire logic ref_clk_i, // Reference clock, 25 MHz
    input wire logic nrst_i, // Asynchronous reset, active low
    input wire csi_pkg::mode_t mode_i, // Timing mode select
    input wire logic overflow_clr_i, // Clears overflow flag
    input wire logic camera_pixel_clock_i, // Sensor pixel clock
    input wire logic camera_frame_sync_i, // Sensor frame sync pin
    input wire logic camera_line_sync_i, // Sensor line sync pin
    input wire logic [csi_pkg::BUS_W-1:0] camera_pixel_bus_i, // Pixel bus
    output logic [csi_pkg::BUS_W-1:0] pix_data_o, // Pixel word
    output logic pix_valid_o, // Pixel word strobe
    output logic pix_sof_o, // First pixel of frame
    output logic pix_sol_o, // First pixel of line
    output logic frame_sync_o, // Recovered frame level
    output logic line_sync_o, // Recovered line level
    output logic overflow_o // Word dropped, sticky
);
    import csi_pkg::*;

    cam_word_if dw ();

    logic prst_s1_r, prst_s2_r;
    logic prst_n;

    // Pixel domain state
    logic [BUS_W-1:0] in_r, in_nxt;
    logic fs_r, fs_nxt;
    logic ls_r, ls_nxt;
    mode_t mode_s1_r, mode_s1_nxt;
    mode_t mode_s2_r, mode_s2_nxt;
    mode_t mode_s3_r, mode_s3_nxt;
    mode_t mode_use_r, mode_use_nxt;
    logic ack_s1_r, ack_s1_nxt;
    logic ack_s2_r, ack_s2_nxt;
    word_t hold_r, hold_nxt;
    logic req_t_r, req_t_nxt;
    logic drop_t_r, drop_t_nxt;
    logic busy;

    // Reference domain state
    logic req_s1_r, req_s1_nxt;
    logic req_s2_r, req_s2_nxt;
    logic req_s3_r, req_s3_nxt;
    logic drop_s1_r, drop_s1_nxt;
    logic drop_s2_r, drop_s2_nxt;
    logic drop_s3_r, drop_s3_nxt;
    logic fl_s1_r, fl_s1_nxt;
    logic fl_s2_r, fl_s2_nxt;
    logic ll_s1_r, ll_s1_nxt;
    logic ll_s2_r, ll_s2_nxt;
    logic ack_t_r, ack_t_nxt;
    logic [BUS_W-1:0] data_r, data_nxt;
    logic valid_r, valid_nxt;
    logic sof_r, sof_nxt;
    logic sol_r, sol_nxt;
    logic ovf_r, ovf_nxt;
    logic new_word;
    logic new_drop;

    // Pixel domain reset: asserts at once, releases on the pixel clock
    always_ff @(posedge camera_pixel_clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prst_s1_r <= 1'h0;
            prst_s2_r <= 1'h0;
        end else begin
            prst_s1_r <= 1'h1;
            prst_s2_r <= prst_s1_r;
        end
    end
    assign prst_n = prst_s2_r;

    // Timing recovery on the pixel clock
    cam_timing_decoder u_dec (
        .pix_clk_i (camera_pixel_clock_i),
        .prst_n_i (prst_n),
        .mode_i (mode_use_r),
        .bus_i (in_r),
        .fs_i (fs_r),
        .ls_i (ls_r),
        .wo (dw.dec)
    );

    assign busy = req_t_r ^ ack_s2_r;

    // Pin capture, mode sync and sending half of the word handshake
    always_comb begin
        in_nxt = camera_pixel_bus_i;
        fs_nxt = camera_frame_sync_i;
        ls_nxt = camera_line_sync_i;
        mode_s1_nxt = mode_i;
        mode_s2_nxt = mode_s1_r;
        // New mode applied after two equal samples; skewed bits filtered
        mode_s3_nxt = mode_s2_r;
        mode_use_nxt = mode_use_r;
        if (mode_s2_r == mode_s3_r) mode_use_nxt = mode_s3_r;
        ack_s1_nxt = ack_t_r;
        ack_s2_nxt = ack_s1_r;
        hold_nxt = hold_r;
        req_t_nxt = req_t_r;
        drop_t_nxt = drop_t_r;
        if (dw.stb) begin
            if (!busy) begin
                hold_nxt = dw.w;
                req_t_nxt = !req_t_r;
            end else begin
                drop_t_nxt = !drop_t_r;
            end
        end
    end

    always_ff @(posedge camera_pixel_clock_i or negedge prst_n) begin
        if (!prst_n) begin
            in_r <= '0;
            fs_r <= 1'h0;
            ls_r <= 1'h0;
            mode_s1_r <= MODE_BT656;
            mode_s2_r <= MODE_BT656;
            mode_s3_r <= MODE_BT656;
            mode_use_r <= MODE_BT656;
            ack_s1_r <= 1'h0;
            ack_s2_r <= 1'h0;
            hold_r <= '0;
            req_t_r <= 1'h0;
            drop_t_r <= 1'h0;
        end else begin
            in_r <= in_nxt;
            fs_r <= fs_nxt;
            ls_r <= ls_nxt;
            mode_s1_r <= mode_s1_nxt;
            mode_s2_r <= mode_s2_nxt;
            mode_s3_r <= mode_s3_nxt;
            mode_use_r <= mode_use_nxt;
            ack_s1_r <= ack_s1_nxt;
            ack_s2_r <= ack_s2_nxt;
            hold_r <= hold_nxt;
            req_t_r <= req_t_nxt;
            drop_t_r <= drop_t_nxt;
        end
    end

    assign new_word = req_s2_r ^ req_s3_r;
    assign new_drop = drop_s2_r ^ drop_s3_r;

    // Receiving half of the handshake and level synchronisers
    always_comb begin
        req_s1_nxt = req_t_r;
        req_s2_nxt = req_s1_r;
        req_s3_nxt = req_s2_r;
        drop_s1_nxt = drop_t_r;
        drop_s2_nxt = drop_s1_r;
        drop_s3_nxt = drop_s2_r;
        fl_s1_nxt = dw.frame_lvl;
        fl_s2_nxt = fl_s1_r;
        ll_s1_nxt = dw.line_lvl;
        ll_s2_nxt = ll_s1_r;
        ack_t_nxt = req_s2_r;
        data_nxt = data_r;
        sof_nxt = sof_r;
        sol_nxt = sol_r;
        valid_nxt = new_word;
        if (new_word) begin
            data_nxt = hold_r.data;
            sof_nxt = hold_r.sof;
            sol_nxt = hold_r.sol;
        end
        // A drop arriving with a clear still sets the flag
        ovf_nxt = ovf_r && !overflow_clr_i;
        if (new_drop) ovf_nxt = 1'h1;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_s1_r <= 1'h0;
            req_s2_r <= 1'h0;
            req_s3_r <= 1'h0;
            drop_s1_r <= 1'h0;
            drop_s2_r <= 1'h0;
            drop_s3_r <= 1'h0;
            fl_s1_r <= 1'h0;
            fl_s2_r <= 1'h0;
            ll_s1_r <= 1'h0;
            ll_s2_r <= 1'h0;
            ack_t_r <= 1'h0;
            data_r <= '0;
            valid_r <= 1'h0;
            sof_r <= 1'h0;
            sol_r <= 1'h0;
            ovf_r <= 1'h0;
        end else begin
            req_s1_r <= req_s1_nxt;
            req_s2_r <= req_s2_nxt;
            req_s3_r <= req_s3_nxt;
            drop_s1_r <= drop_s1_nxt;
            drop_s2_r <= drop_s2_nxt;
            drop_s3_r <= drop_s3_nxt;
            fl_s1_r <= fl_s1_nxt;
            fl_s2_r <= fl_s2_nxt;
            ll_s1_r <= ll_s1_nxt;
            ll_s2_r <= ll_s2_nxt;
            ack_t_r <= ack_t_nxt;
            data_r <= data_nxt;
            valid_r <= valid_nxt;
            sof_r <= sof_nxt;
            sol_r <= sol_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    // Outputs straight from flops
    assign pix_data_o = data_r;
    assign pix_valid_o = valid_r;
    assign pix_sof_o = sof_r;
    assign pix_sol_o = sol_r;
    assign frame_sync_o = fl_s2_r;
    assign line_sync_o = ll_s2_r;
    assign overflow_o = ovf_r;

    // Checks on the crossing
    a_hold_stable: assert property (@(posedge camera_pixel_clock_i)
        disable iff (!prst_n)
        busy |=> hold_r == $past(hold_r))
        else $error("held word changed during handshake");
    a_valid_single: assert property (@(posedge ref_clk_i)
        disable iff (!nrst_i)
        pix_valid_o |=> !pix_valid_o)
        else $error("pixel strobe longer than one cycle");
    a_valid_data: assert property (@(posedge ref_clk_i)
        disable iff (!nrst_i)
        new_word |=> pix_valid_o && pix_data_o == $past(hold_r.data))
        else $error("crossed word does not match held word");
    a_ovf_sticky: assert property (@(posedge ref_clk_i)
        disable iff (!nrst_i)
        overflow_o && !overflow_clr_i |=> overflow_o)
        else $error("overflow flag lost without clear");

endmodule

// [testbench/sensor_model.sv]
/*
 * Behavioural camera sensor: pixel clock, sync pins and pixel bus.
 * Assumes the bench raises run_i while it sends a frame.
 */
`timescale 1ns/1ps
module sensor_model (
    input wire logic run_i, // Let the pixel clock run
    output logic pclk_o, // Pixel clock, 32 ns period
    output logic fsync_o, // Frame sync level
    output logic lsync_o, // Line sync level
    output logic [csi_pkg::BUS_W-1:0] bus_o // Pixel bus
);
    import csi_pkg::*;

    // Clock stands low outside frames; phase offset to the ref clock
    initial begin
        pclk_o = 1'b0;
        fsync_o = 1'b0;
        lsync_o = 1'b0;
        bus_o = '0;
        #7;
        forever begin
            #16;
            if (run_i || pclk_o) begin
                pclk_o = ~pclk_o;
            end
        end
    end

    // One word just after a rising pixel clock edge
    task automatic word(input logic [15:0] d, input logic f, input logic l);
        @(posedge pclk_o);
        #2;
        bus_o = d;
        fsync_o = f;
        lsync_o = l;
    endtask

    // Idle or blanking words: bus shows the inverse of its last value
    task automatic idle(input int n, input logic f, input logic l);
        repeat (n) word(~bus_o, f, l);
    endtask

    // Timing code: ones, zeros, zeros, then flag word
    task automatic code(input logic [7:0] xy, input logic f, input logic l);
        word({2{PRE_ONES}}, f, l);
        word({2{PRE_ZERO}}, f, l);
        word({2{PRE_ZERO}}, f, l);
        word({2{xy}}, f, l);
    endtask
endmodule

// [testbench/testbench.sv]
/*
 * Self-checking bench for the camera sensor input port.
 * Assumes the sensor model in sensor_model.sv and the csi_pkg package.
 */
`timescale 1ns/1ps
module testbench;
    import csi_pkg::*;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic overflow_clr_i = 1'b0;
    logic run = 1'b1;
    mode_t mode_i = MODE_BT656;
    logic pclk, fsync, lsync;
    logic [BUS_W-1:0] bus, pix_data_o;
    logic pix_valid_o, pix_sof_o, pix_sol_o;
    logic frame_sync_o, line_sync_o, overflow_o;
    int error_cnt = 0;
    int compares = 0;
    logic [BUS_W+1:0] q[$];

    sensor_model sensor (.run_i(run), .pclk_o(pclk), .fsync_o(fsync),
        .lsync_o(lsync), .bus_o(bus));

    camera_sensor_input_port dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .mode_i(mode_i), .overflow_clr_i(overflow_clr_i),
        .camera_pixel_clock_i(pclk), .camera_frame_sync_i(fsync),
        .camera_line_sync_i(lsync), .camera_pixel_bus_i(bus),
        .pix_data_o(pix_data_o), .pix_valid_o(pix_valid_o),
        .pix_sof_o(pix_sof_o), .pix_sol_o(pix_sol_o),
        .frame_sync_o(frame_sync_o), .line_sync_o(line_sync_o),
        .overflow_o(overflow_o));

    // Reference clock, 40 ns
    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // Collect every delivered word with its tags
    always @(posedge ref_clk_i) begin
        if (pix_valid_o === 1'b1) begin
            q.push_back({pix_sof_o, pix_sol_o, pix_data_o});
        end
    end

    task automatic check(input logic [BUS_W+1:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Start clock and mode, then idle words so mode sync settles
    task automatic start(input mode_t m);
        @(posedge ref_clk_i);
        #2;
        q.delete();
        mode_i = m;
        run = 1'b1;
        sensor.idle(10, 1'b0, 1'b0);
    endtask

    // Bounded wait for n words, then settle to catch extras
    task automatic wait_words(input int n);
        for (int i = 0; i < 400 && q.size() < n; i++) @(posedge ref_clk_i);
        if (q.size() < n) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                q.size(), n);
            stop_test();
        end else begin
            repeat (20) @(posedge ref_clk_i);
            #2;
        end
    endtask

    task automatic done(input string name);
        run = 1'b0;
        $display("test %s finished", name);
    endtask

    // Embedded sync; sync pins held high and must be ignored
    task automatic test_embedded(input mode_t m, input logic [15:0] p0, p1);
        logic [15:0] e0, e1;
        e0 = (m == MODE_BT656) ? {8'h00, p0[7:0]} : p0;
        e1 = (m == MODE_BT656) ? {8'h00, p1[7:0]} : p1;
        start(m);
        sensor.code(8'ha0, 1'b1, 1'b1);
        sensor.idle(3, 1'b1, 1'b1);
        sensor.code(8'hb0, 1'b1, 1'b1);
        sensor.idle(8, 1'b1, 1'b1);
        sensor.code(8'h80, 1'b1, 1'b1);
        sensor.word(p0, 1'b1, 1'b1);
        sensor.code(8'h90, 1'b1, 1'b1);
        sensor.idle(10, 1'b1, 1'b1);
        sensor.code(8'h80, 1'b1, 1'b1);
        sensor.word(p1, 1'b1, 1'b1);
        sensor.code(8'h90, 1'b1, 1'b1);
        sensor.idle(10, 1'b1, 1'b1);
        wait_words(2);
        check(18'(q.size()), 18'h2);
        check({2'b00, q[0][15:0]}, {2'b00, e0});
        check({2'b00, q[1][15:0]}, {2'b00, e1});
        check({14'h0, q[0][17:16], q[1][17:16]}, 18'hd);
        check({frame_sync_o, line_sync_o}, 2'h2);
        done("embedded");
    endtask

    // Sync-gated modes: words only while line sync high
    task automatic test_gated(input mode_t m, input logic [15:0] g0, g1);
        start(m);
        sensor.idle(2, 1'b1, 1'b0);
        sensor.word(g0, 1'b1, 1'b1);
        sensor.idle(10, 1'b1, 1'b0);
        check({16'h0, frame_sync_o, line_sync_o}, 18'h2);
        sensor.word(g1, 1'b1, 1'b1);
        sensor.idle(10, 1'b0, 1'b0);
        wait_words(2);
        check(18'(q.size()), 18'h2);
        check(q[0], {2'b11, g0});
        check(q[1], {2'b01, g1});
        check({16'h0, frame_sync_o, line_sync_o}, 18'h0);
        done("gated");
    endtask

    // Back-to-back pixels overrun the crossing; flag then clear
    task automatic test_overflow;
        start(MODE_BT656);
        check({17'h0, overflow_o}, 18'h0);
        sensor.code(8'ha0, 1'b0, 1'b0);
        sensor.code(8'hb0, 1'b0, 1'b0);
        sensor.idle(4, 1'b0, 1'b0);
        sensor.code(8'h80, 1'b0, 1'b0);
        for (int i = 1; i < 7; i++) begin
            sensor.word({8'h00, 8'(i * 17)}, 1'b0, 1'b0);
        end
        sensor.code(8'h90, 1'b0, 1'b0);
        sensor.idle(10, 1'b0, 1'b0);
        wait_words(1);
        check(q[0], {2'b11, 16'h0011});
        check({17'h0, q.size() < 6}, 18'h1);
        check({17'h0, overflow_o}, 18'h1);
        overflow_clr_i = 1'b1;
        @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        #2;
        overflow_clr_i = 1'b0;
        check({17'h0, overflow_o}, 18'h0);
        done("overflow");
    endtask

    // Main sequence: reset, every mode, then overrun
    initial begin
        repeat (6) @(posedge ref_clk_i);
        #2;
        nrst_i = 1'b1;
        test_embedded(MODE_BT656, 16'h5a3c, 16'ha5c3);
        test_embedded(MODE_BT1120, 16'h1234, 16'hbeef);
        test_gated(MODE_GATED, 16'hc001, 16'h7e81);
        test_gated(MODE_ALT, 16'h0f1e, 16'hd2a5);
        test_overflow();
        stop_test();
    end
endmodule
